/* common/bias_regs_map.svh */
// Register offsets, field positions, reset values and codes of the bias register bank
`ifndef BIAS_REGS_MAP_SVH
`define BIAS_REGS_MAP_SVH

// Register addresses (decimal in the map, held here as 5-bit hex)
`define ADDR_SYSTEM_CONTROL      5'h00
`define ADDR_CARRIER_REFERENCE   5'h01
`define ADDR_CARRIER_DRIVER      5'h02
`define ADDR_CARRIER_FINAL       5'h03
`define ADDR_PEAKING_REFERENCE   5'h04
`define ADDR_PEAKING_DRIVER      5'h05
`define ADDR_PEAKING_FINAL       5'h06
`define ADDR_TEMPERATURE         5'h0F
`define ADDR_UNLOCK_CODE         5'h11

// System control field positions
`define SYSCTL_SOFT_RESET_BIT    6
`define SYSCTL_RELOAD_BIT        5
`define SYSCTL_REV_MSB           3
`define SYSCTL_REV_LSB           0

// Reference field width and unused bits
`define REF_MSB                  5

// Default values: references and gate offsets when one-time memory is blank, temperature and control bits on reset
`define REF_DEFAULT              6'h20
`define GATE_DEFAULT             8'h80
`define TEMP_DEFAULT             8'h00
`define CTL_BIT_DEFAULT          1'h0

// Unlock code
`define UNLOCK_CODE_VALUE        8'hE3

// Zero for reserved reads
`define READ_ZERO                8'h00

`endif

/* common/bias_regs_pkg.sv */
// Types shared by the bias register bank
package bias_regs_pkg;

	// Register access request from the serial front end
	typedef struct packed {
		logic       wr;    // Write strobe, one cycle
		logic       rd;    // Read strobe, one cycle
		logic [4:0] addr;  // Register address
		logic [7:0] wdata; // Write data
	} reg_req_t;

	// Complete set of settings held by the bank
	typedef struct packed {
		logic [5:0] carrier_ref;
		logic [7:0] carrier_drv;
		logic [7:0] carrier_fin;
		logic [5:0] peaking_ref;
		logic [7:0] peaking_drv;
		logic [7:0] peaking_fin;
	} settings_t;

	// Load source of the settings
	typedef enum logic [1:0] {
		LOAD_NONE,
		LOAD_MEMORY,
		LOAD_DEFAULT
	} load_src_t;

endpackage

/* logic/bias_control_register_bank.sv */
// Register bank of the autobias controller: settings, control, temperature, unlock
//
// Contract
// - Soft reset bit returns all registers to default; the code loads memory values into settings when memory is programmed
// - Reload bit copies memory values into settings
// - Revision bits fixed, read-only, writes ignored
// - Carrier reference six bits, default 6'h20
// - Peaking reference same layout, default 6'h20
// - Reference usable range 6'b001000 to 6'b111111
// - Four gate offsets, default 8'h80
// - Temperature at 15, read-only, reset zero
// - Writing 8'hE3 to 17 enters unlock mode
// - Any other unlock value leaves unlock mode
// - Settings always readable, written only unlocked
// - Reset loads memory values into settings
// - Defaults apply only when memory blank
// - Unlocked writes lost on reset
// - Unlocked, addresses 1 to 6 take writes
`timescale 1ns/10ps
`include "bias_regs_map.svh"

module bias_control_register_bank
#(
	parameter logic [3:0] REVISION = 4'h1 // Revision value, arbitrary
)
(
	// Clock and reset
	input  wire logic                        SYS_CLK_I,
	input  wire logic                        SYS_RST_I,
	// Register access from the serial front end
	input  wire bias_regs_pkg::reg_req_t     REQ_I,
	output logic [7:0]                       RDATA_O,
	output logic                             RVALID_O,
	// One-time memory contents
	input  wire logic                        MEM_PROGRAMMED_I,
	input  wire bias_regs_pkg::settings_t    MEM_VALUES_I,
	// Temperature converter result
	input  wire logic [7:0]                  TEMP_VALUE_I,
	input  wire logic                        TEMP_VALID_I,
	// Settings to the bias loop
	output bias_regs_pkg::settings_t         SETTINGS_O,
	output logic                             UNLOCK_MODE_O
);

	// Settings currently in force
	bias_regs_pkg::settings_t  set_r;
	// Soft reset and reload control bits
	logic                      soft_reset_r;
	logic                      reload_r;
	// Unlock state
	logic                      unlock_mode_r;
	// Latest temperature reading
	logic [7:0]                temp_r;
	// Load request: pending while the soft reset or reload bit is set
	bias_regs_pkg::load_src_t  load_nxt;
	// Decoded writes
	logic                      wr_sysctl;
	logic                      wr_unlock;
	logic                      wr_setting;
	// Read mux result
	logic [7:0]                rdata_nxt;

	// Revision must fit the four-bit field; nothing else to check
	initial
	begin
		if ($bits(REVISION) != 4)
			$error("REVISION must be four bits");
	end

	// Write decode
	always_comb
	begin
		wr_sysctl  = REQ_I.wr && (REQ_I.addr == `ADDR_SYSTEM_CONTROL);
		wr_unlock  = REQ_I.wr && (REQ_I.addr == `ADDR_UNLOCK_CODE);
		wr_setting = REQ_I.wr && unlock_mode_r;
	end

	// Choose which source refills the settings this cycle
	always_comb
	begin
		load_nxt = bias_regs_pkg::LOAD_NONE;
		if (soft_reset_r)
			load_nxt = bias_regs_pkg::LOAD_DEFAULT;
		else if (reload_r)
			load_nxt = bias_regs_pkg::LOAD_MEMORY;
	end

	// Control bits; held while set so the action repeats until the host clears them
	always_ff @(posedge SYS_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			soft_reset_r <= `CTL_BIT_DEFAULT;
			reload_r     <= `CTL_BIT_DEFAULT;
		end
		else if (wr_sysctl)
		begin
			soft_reset_r <= REQ_I.wdata[`SYSCTL_SOFT_RESET_BIT];
			reload_r     <= REQ_I.wdata[`SYSCTL_RELOAD_BIT];
		end
	end

	// Unlock mode tracking
	always_ff @(posedge SYS_CLK_I)
	begin
		if (SYS_RST_I || soft_reset_r)
			unlock_mode_r <= 1'b0;
		else if (wr_unlock)
			unlock_mode_r <= (REQ_I.wdata == `UNLOCK_CODE_VALUE);
	end

	// Setting registers
	always_ff @(posedge SYS_CLK_I)
	begin
		// reset loads memory; defaults only if blank; edits lost
		if (SYS_RST_I || load_nxt == bias_regs_pkg::LOAD_MEMORY)
		begin
			if (MEM_PROGRAMMED_I)
				set_r <= MEM_VALUES_I;
			else
			begin
				set_r.carrier_ref <= `REF_DEFAULT;
				set_r.carrier_drv <= `GATE_DEFAULT;
				set_r.carrier_fin <= `GATE_DEFAULT;
				set_r.peaking_ref <= `REF_DEFAULT;
				set_r.peaking_drv <= `GATE_DEFAULT;
				set_r.peaking_fin <= `GATE_DEFAULT;
			end
		end
		// soft reset loads memory values; defaults only if blank
		else if (load_nxt == bias_regs_pkg::LOAD_DEFAULT)
		begin
			if (MEM_PROGRAMMED_I)
				set_r <= MEM_VALUES_I;
			else
			begin
				set_r.carrier_ref <= `REF_DEFAULT;
				set_r.carrier_drv <= `GATE_DEFAULT;
				set_r.carrier_fin <= `GATE_DEFAULT;
				set_r.peaking_ref <= `REF_DEFAULT;
				set_r.peaking_drv <= `GATE_DEFAULT;
				set_r.peaking_fin <= `GATE_DEFAULT;
			end
		end
		else if (wr_setting)
		begin
			// reference keeps its six low bits, full range stored
			if (REQ_I.addr == `ADDR_CARRIER_REFERENCE)
				set_r.carrier_ref <= REQ_I.wdata[`REF_MSB:0];
			// gate offsets take the whole byte
			else if (REQ_I.addr == `ADDR_CARRIER_DRIVER)
				set_r.carrier_drv <= REQ_I.wdata;
			else if (REQ_I.addr == `ADDR_CARRIER_FINAL)
				set_r.carrier_fin <= REQ_I.wdata;
			else if (REQ_I.addr == `ADDR_PEAKING_REFERENCE)
				set_r.peaking_ref <= REQ_I.wdata[`REF_MSB:0];
			else if (REQ_I.addr == `ADDR_PEAKING_DRIVER)
				set_r.peaking_drv <= REQ_I.wdata;
			else if (REQ_I.addr == `ADDR_PEAKING_FINAL)
				set_r.peaking_fin <= REQ_I.wdata;
		end
	end

	// Temperature holding register
	always_ff @(posedge SYS_CLK_I)
	begin
		// reset value zero, also on soft reset
		if (SYS_RST_I || soft_reset_r)
			temp_r <= `TEMP_DEFAULT;
		else if (TEMP_VALID_I)
			temp_r <= TEMP_VALUE_I;
	end

	// Read multiplexer
	always_comb
	begin
		rdata_nxt = `READ_ZERO;
		if (REQ_I.addr == `ADDR_SYSTEM_CONTROL)
		begin
			// fixed revision; bits 7 and 4 zero
			rdata_nxt[`SYSCTL_SOFT_RESET_BIT]            = soft_reset_r;
			rdata_nxt[`SYSCTL_RELOAD_BIT]                = reload_r;
			rdata_nxt[`SYSCTL_REV_MSB:`SYSCTL_REV_LSB]   = REVISION;
		end
		else if (REQ_I.addr == `ADDR_CARRIER_REFERENCE)
			rdata_nxt = {2'h0, set_r.carrier_ref};
		else if (REQ_I.addr == `ADDR_CARRIER_DRIVER)
			rdata_nxt = set_r.carrier_drv;
		else if (REQ_I.addr == `ADDR_CARRIER_FINAL)
			rdata_nxt = set_r.carrier_fin;
		else if (REQ_I.addr == `ADDR_PEAKING_REFERENCE)
			rdata_nxt = {2'h0, set_r.peaking_ref};
		else if (REQ_I.addr == `ADDR_PEAKING_DRIVER)
			rdata_nxt = set_r.peaking_drv;
		else if (REQ_I.addr == `ADDR_PEAKING_FINAL)
			rdata_nxt = set_r.peaking_fin;
		else if (REQ_I.addr == `ADDR_TEMPERATURE)
			rdata_nxt = temp_r;
		// reserved and write-only addresses read zero
		else
			rdata_nxt = `READ_ZERO;
	end

	// Registered read answer, one cycle after the strobe
	always_ff @(posedge SYS_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			RDATA_O  <= `READ_ZERO;
			RVALID_O <= 1'b0;
		end
		else
		begin
			RVALID_O <= REQ_I.rd;
			if (REQ_I.rd)
				RDATA_O <= rdata_nxt;
		end
	end

	// Outputs to the bias loop
	assign SETTINGS_O    = set_r;
	assign UNLOCK_MODE_O = unlock_mode_r;

endmodule

/* tb/bias_regs_monitor.sv */
// Port checks of the bias register bank
`timescale 1ns/10ps
module bias_regs_monitor
#(
	parameter logic [3:0] REVISION = 4'h1 // Arbitrary revision
)
(
	// Clock, reset and requests
	input wire logic	SYS_CLK_I,
	input wire logic	SYS_RST_I,
	input wire bias_regs_pkg::reg_req_t	REQ_I,
	// Answers, sources and settings
	input wire logic [7:0]	RDATA_O,
	input wire logic	RVALID_O,
	input wire logic	MEM_PROGRAMMED_I,
	input wire bias_regs_pkg::settings_t	MEM_VALUES_I,
	input wire logic [7:0]	TEMP_VALUE_I,
	input wire logic	TEMP_VALID_I,
	input wire bias_regs_pkg::settings_t	SETTINGS_O,
	input wire logic	UNLOCK_MODE_O
);
	// Values used when the memory is blank
	localparam bias_regs_pkg::settings_t DFLT = {6'h20, 8'h80, 8'h80, 6'h20, 8'h80, 8'h80};
	wire		wr = REQ_I.wr;	// Write strobe
	wire		rd = REQ_I.rd;	// Read strobe
	wire [4:0]	ad = REQ_I.addr;	// Register address
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	a_read_answer: assert property (rd |=> RVALID_O) else $error("read unanswered");
	a_valid_cause: assert property (!rd |=> !RVALID_O) else $error("stray valid");
	a_unlock_enter: assert property (wr && ad == 5'h11 && REQ_I.wdata == 8'hE3
		|=> UNLOCK_MODE_O) else $error("code not taken");
	a_unlock_leave: assert property (wr && ad == 5'h11 && REQ_I.wdata != 8'hE3
		|=> !UNLOCK_MODE_O) else $error("unlock kept");
	a_locked_ignore: assert property (!UNLOCK_MODE_O && wr && ad inside {[1:6]}
		|=> $stable(SETTINGS_O)) else $error("locked write taken");
	a_unlock_write: assert property (UNLOCK_MODE_O && wr && ad == 5'h02
		|=> SETTINGS_O.carrier_drv == $past(REQ_I.wdata)) else $error("offset lost");
	a_ref_width: assert property (UNLOCK_MODE_O && wr && ad == 5'h01
		|=> SETTINGS_O.carrier_ref == $past(REQ_I.wdata[5:0])) else $error("ref lost");
	a_reserved_zero: assert property (rd && ad inside {[7:14], 16}
		|=> RDATA_O == 8'h00) else $error("reserved not zero");
	a_ctl_readback: assert property (rd && ad == 5'h00
		|=> RDATA_O[3:0] == REVISION && !RDATA_O[7] && !RDATA_O[4]) else $error("bad ctl");
	a_reset_load: assert property (@(posedge SYS_CLK_I) disable iff (1'b0) SYS_RST_I
		|=> SETTINGS_O == ($past(MEM_PROGRAMMED_I) ? $past(MEM_VALUES_I) : DFLT)
		&& !UNLOCK_MODE_O) else $error("bad reset load");
	c_unlocked: cover property (UNLOCK_MODE_O && wr && ad == 5'h01);
	c_temp: cover property (TEMP_VALID_I ##[1:4] rd && ad == 5'h0F);
	c_blank: cover property ($fell(SYS_RST_I) && !MEM_PROGRAMMED_I);
endmodule
bind bias_control_register_bank bias_regs_monitor #(.REVISION(REVISION)) i_bias_regs_monitor (
	.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .REQ_I(REQ_I), .RDATA_O(RDATA_O),
	.RVALID_O(RVALID_O), .MEM_PROGRAMMED_I(MEM_PROGRAMMED_I), .MEM_VALUES_I(MEM_VALUES_I),
	.TEMP_VALUE_I(TEMP_VALUE_I), .TEMP_VALID_I(TEMP_VALID_I), .SETTINGS_O(SETTINGS_O),
	.UNLOCK_MODE_O(UNLOCK_MODE_O));

/* tb/bias_host.sv */
// Host model issuing single register requests
`timescale 1ns/10ps
module bias_host
(
	// Clock
	input wire logic	CLK_I,
	// Requests to the bank
	output bias_regs_pkg::reg_req_t	REQ_O
);
	initial REQ_O = '0;
	task automatic put(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge CLK_I);
		#1 REQ_O = '{w, !w, a, d};
		@(posedge CLK_I);
		// Released lines show the inverse, never a stale value
		#1 REQ_O = '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule

/* tb/test_bias_control_register_bank.sv */
// Self-checking bench of the bias register bank
`timescale 1ns/10ps
module test_bias_control_register_bank;
	localparam logic [3:0] REV = 4'h6; // Arbitrary revision
	logic		clk = 1'b0;	// 200 MHz clock
	logic		rst = 1'b1;	// Synchronous reset
	logic		mp = 1'b1;	// Memory programmed
	logic		tv = 1'b0;	// Temperature strobe
	logic [7:0]	tval = 8'h00;	// Temperature value
	logic [7:0]	t;	// Captured temperature
	logic [7:0]	rdat;	// Read data
	logic		rv;	// Read valid
	logic		unl;	// Unlock flag
	logic		eu;	// Expected unlock
	logic [31:0]	seed = 32'h890809EB;
	bias_regs_pkg::reg_req_t	req;
	bias_regs_pkg::settings_t	mem, st, ex;
	bias_regs_pkg::settings_t	dft = {6'h20, 8'h80, 8'h80, 6'h20, 8'h80, 8'h80};
	logic [7:0]	q[$];	// Expected read data, oldest first
	int	fail_count = 0;
	int	num_checks = 0;
	always #2.5 clk = ~clk;
	bias_host i_bias_host (.CLK_I(clk), .REQ_O(req));
	bias_control_register_bank #(.REVISION(REV)) i_bias_control_register_bank (
		.SYS_CLK_I(clk), .SYS_RST_I(rst), .REQ_I(req), .RDATA_O(rdat), .RVALID_O(rv),
		.MEM_PROGRAMMED_I(mp), .MEM_VALUES_I(mem), .TEMP_VALUE_I(tval),
		.TEMP_VALID_I(tv), .SETTINGS_O(st), .UNLOCK_MODE_O(unl));
	// Random settings, references kept in the recommended range
	function automatic bias_regs_pkg::settings_t rs();
		bias_regs_pkg::settings_t n;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		n = {seed, seed[31:20]};
		n.carrier_ref[5] = 1'b1;
		n.peaking_ref[5] = 1'b1;
		return n;
	endfunction
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("FAIL %0t read %h expected %h", $time, g, e);
		end
	endtask
	// Compare unlock flag and settings outputs with the mirror
	task automatic sc();
		num_checks++;
		if ({unl, st} !== {eu, ex})
		begin
			fail_count++;
			$display("FAIL %0t state %h expected %h", $time, {unl, st}, {eu, ex});
		end
	endtask
	task automatic w(input logic [4:0] a, input logic [7:0] d);
		i_bias_host.put(1'b1, a, d);
	endtask
	task automatic r(input logic [4:0] a, input logic [7:0] e);
		q.push_back(e);
		i_bias_host.put(1'b0, a, 8'h00);
	endtask
	// Write all six settings, junk in unused reference bits
	task automatic wset(input bias_regs_pkg::settings_t n);
		w(5'h01, {seed[7:6], n.carrier_ref});
		w(5'h02, n.carrier_drv);
		w(5'h03, n.carrier_fin);
		w(5'h04, {seed[9:8], n.peaking_ref});
		w(5'h05, n.peaking_drv);
		w(5'h06, n.peaking_fin);
		if (eu)
			ex = n;
	endtask
	task automatic rall();
		r(5'h01, {2'h0, ex.carrier_ref});
		r(5'h02, ex.carrier_drv);
		r(5'h03, ex.carrier_fin);
		r(5'h04, {2'h0, ex.peaking_ref});
		r(5'h05, ex.peaking_drv);
		r(5'h06, ex.peaking_fin);
	endtask
	task automatic reset_run(input logic p);
		mp = p;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		ex = p ? mem : dft;
		eu = 1'b0;
	endtask
	task automatic tally_and_finish();
		if (q.size() != 0)
		begin
			fail_count++;
			$display("FAIL %0t reads unanswered", $time);
		end
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Scoreboard: each valid answer takes the oldest expectation
	always @(negedge clk)
		if (rv === 1'b1)
		begin
			if (q.size() == 0)
			begin
				fail_count++;
				$display("FAIL %0t answer without read", $time);
			end
			else
				cmp(rdat, q.pop_front());
		end
	initial
	begin
		mem = rs();
		reset_run(1'b1);
		sc();
		rall();
		r(5'h0F, 8'h00);
		w(5'h00, 8'h9F);
		r(5'h00, {4'h0, REV});
		wset(rs());
		sc();
		w(5'h11, 8'hE3);
		eu = 1'b1;
		sc();
		wset(rs());
		sc();
		rall();
		for (logic [4:0] a = 5'h07; a < 5'h12; a++)
		begin
			w(a, 8'hFF);
			r(a, 8'h00);
		end
		eu = 1'b0;
		sc();
		wset(rs());
		sc();
		t = seed[7:0];
		@(posedge clk);
		#1 {tv, tval} = {1'b1, t};
		@(posedge clk);
		#1 {tv, tval} = {1'b0, ~t};
		r(5'h0F, t);
		w(5'h11, 8'hE3);
		eu = 1'b1;
		wset(rs());
		w(5'h00, 8'h20);
		w(5'h00, 8'h00);
		ex = mem;
		sc();
		wset(rs());
		w(5'h00, 8'h40);
		w(5'h00, 8'h00);
		ex = mem;
		eu = 1'b0;
		sc();
		r(5'h0F, 8'h00);
		w(5'h11, 8'hE3);
		eu = 1'b1;
		wset(rs());
		mem = rs();
		reset_run(1'b0);
		sc();
		rall();
		repeat (2) @(posedge clk);
		tally_and_finish();
	end
endmodule
